// *** hdl/vrc_top.sv ***
// reference and temperature indicator control register behind an axi4-lite slave
// Notes on behaviour
// RULE1: bit 7 switches the reference on/off
// RULE2: ready rises after settling; zero while off
// RULE3: ready is read-only; one means usable
// RULE4: bit 5 switches temperature indicator
// RULE5: bit 4 picks high or low range
// RULE6: bits 3:2 decode comparator/dac buffer gain
// RULE7: bits 1:0 decode adc buffer gain
// RULE8: two independent gain outputs, 1x/2x/4x
// RULE9: control register at 0x90c, resets zero
// RULE10: indicator idle, no bias, while disabled
// RULE11: writes to the ready bit ignored
`include "vrc_regs.svh"

module vrc_top
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic reference_enable,
	output logic reference_ready,
	output logic temp_sense_enable,
	output logic temp_range_select,
	output logic adc_ref_buf_on,
	output logic [2:0] adc_ref_gain_sel,
	output logic cmp_dac_buf_on,
	output logic [2:0] comparator_dac_gain_sel
);

	vrc_pkg::vrc_state_s st_q;
	vrc_pkg::vrc_state_s st_d;
	logic settled;

	// the settle timer watches the stored enable, not the bus
	vrc_settle u_settle
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(st_q.ctrl[`VRC_BIT_REF_EN]),
		.ready(settled)
	);

	always_comb
	begin
		st_d = st_q;

		// write address and data are taken independently, in either order
		if (s_axi_awvalid && st_q.awready)
		begin
			st_d.aw_got = 1'b1;
			st_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_q.wready)
		begin
			st_d.w_got = 1'b1;
			st_d.wdata = s_axi_wdata[7:0];
			st_d.wstrb0 = s_axi_wstrb[0];
		end

		if (st_q.aw_got && st_q.w_got && !st_q.bvalid)
		begin
			st_d.aw_got = 1'b0;
			st_d.w_got = 1'b0;
			st_d.bvalid = 1'b1;
			if (st_q.awaddr[11:2] == 10'(`VRC_CTRL_ADDR >> 2)) // see RULE9
			begin
				st_d.bresp = `VRC_RESP_OKAY;
				if (st_q.wstrb0)
				begin
					st_d.ctrl = st_q.wdata; // see RULE1
					st_d.ctrl[`VRC_BIT_REF_READY] = 1'b0; // see RULE11
				end
			end
			else
				st_d.bresp = `VRC_RESP_SLVERR;
		end
		else if (st_q.bvalid && s_axi_bready)
			st_d.bvalid = 1'b0;

		// one outstanding write: no new address or data until the response is gone
		st_d.awready = !st_d.aw_got && !st_d.bvalid;
		st_d.wready = !st_d.w_got && !st_d.bvalid;

		if (s_axi_arvalid && st_q.arready)
		begin
			st_d.rvalid = 1'b1;
			if (s_axi_araddr[11:2] == 10'(`VRC_CTRL_ADDR >> 2)) // see RULE9
			begin
				st_d.rresp = `VRC_RESP_OKAY;
				st_d.rdata = {24'h00_0000, st_q.ctrl};
				st_d.rdata[`VRC_BIT_REF_READY] = st_q.ready; // see RULE3
			end
			else
			begin
				st_d.rresp = `VRC_RESP_SLVERR;
				st_d.rdata = `VRC_RDATA_ZERO;
			end
		end
		else if (st_q.rvalid && s_axi_rready)
			st_d.rvalid = 1'b0;
		st_d.arready = !st_d.rvalid;

		// ready only while enabled, even if the timer lags a disable by a cycle
		st_d.ready = settled && st_d.ctrl[`VRC_BIT_REF_EN]; // see RULE2

		st_d.ref_en = st_d.ctrl[`VRC_BIT_REF_EN]; // see RULE1
		st_d.temp_en = st_d.ctrl[`VRC_BIT_TEMP_EN]; // see RULE4
		// range bias is dropped too while disabled, so nothing draws current
		st_d.temp_high = st_d.ctrl[`VRC_BIT_TEMP_EN]
			&& st_d.ctrl[`VRC_BIT_TEMP_RANGE]; // see RULE5 see RULE10
		st_d.adc = vrc_pkg::vrc_gain_decode(
			st_d.ctrl[`VRC_ADC_GAIN_LSB +: 2]); // see RULE7 see RULE8
		st_d.cmp = vrc_pkg::vrc_gain_decode(
			st_d.ctrl[`VRC_CMP_GAIN_LSB +: 2]); // see RULE6 see RULE8
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_q <= '0;
			st_q.ctrl <= `VRC_CTRL_RESET; // see RULE9
			st_q.awready <= 1'b1;
			st_q.wready <= 1'b1;
			st_q.arready <= 1'b1;
		end
		else
			st_q <= st_d;
	end

	assign s_axi_awready = st_q.awready;
	assign s_axi_wready = st_q.wready;
	assign s_axi_bresp = st_q.bresp;
	assign s_axi_bvalid = st_q.bvalid;
	assign s_axi_arready = st_q.arready;
	assign s_axi_rdata = st_q.rdata;
	assign s_axi_rresp = st_q.rresp;
	assign s_axi_rvalid = st_q.rvalid;
	assign reference_enable = st_q.ref_en;
	assign reference_ready = st_q.ready;
	assign temp_sense_enable = st_q.temp_en;
	assign temp_range_select = st_q.temp_high;
	assign adc_ref_buf_on = st_q.adc.buf_on;
	assign adc_ref_gain_sel = st_q.adc.gain_onehot;
	assign cmp_dac_buf_on = st_q.cmp.buf_on;
	assign comparator_dac_gain_sel = st_q.cmp.gain_onehot;

endmodule : vrc_top

// *** hdl/vrc_regs.svh ***
// offsets, bit positions, reset values and timing counts of the reference control block
`ifndef VRC_REGS_SVH
`define VRC_REGS_SVH

`define VRC_ADDR_W 12
`define VRC_CTRL_ADDR 12'h90c
`define VRC_CTRL_RESET 8'h00
`define VRC_BIT_REF_EN 7
`define VRC_BIT_REF_READY 6
`define VRC_BIT_TEMP_EN 5
`define VRC_BIT_TEMP_RANGE 4
`define VRC_CMP_GAIN_LSB 2
`define VRC_ADC_GAIN_LSB 0
`define VRC_RESP_OKAY 2'h0
`define VRC_RESP_SLVERR 2'h2
`define VRC_RDATA_ZERO 32'h0000_0000
`define VRC_CLK_PERIOD_NS 100
`define VRC_SETTLE_TIME_NS 100
`define VRC_SETTLE_CYCLES ((`VRC_SETTLE_TIME_NS + `VRC_CLK_PERIOD_NS - 1) / `VRC_CLK_PERIOD_NS)
`define VRC_SETTLE_CNT_W 8

`endif

// *** hdl/vrc_pkg.sv ***
// types and the gain decode shared by the reference control block
package vrc_pkg;

	typedef enum logic [1:0]
	{
		VRC_GAIN_OFF = 2'h0,
		VRC_GAIN_1X = 2'h1,
		VRC_GAIN_2X = 2'h2,
		VRC_GAIN_4X = 2'h3
	} vrc_gain_e;

	typedef struct packed
	{
		logic buf_on;
		logic [2:0] gain_onehot;
	} vrc_gain_s;

	typedef struct packed
	{
		logic [7:0] count;
		logic ready;
	} vrc_settle_s;

	typedef struct packed
	{
		logic aw_got;
		logic [11:0] awaddr;
		logic w_got;
		logic [7:0] wdata;
		logic wstrb0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] ctrl;
		logic ready;
		logic ref_en;
		logic temp_en;
		logic temp_high;
		vrc_gain_s adc;
		vrc_gain_s cmp;
	} vrc_state_s;

	// onehot order is {4x, 2x, 1x}; off leaves the buffer unpowered
	function automatic vrc_gain_s vrc_gain_decode(input logic [1:0] code);
		vrc_gain_s g;
		g.buf_on = 1'b1;
		g.gain_onehot = 3'h0;
		case (vrc_gain_e'(code))
			VRC_GAIN_1X: g.gain_onehot = 3'h1;
			VRC_GAIN_2X: g.gain_onehot = 3'h2;
			VRC_GAIN_4X: g.gain_onehot = 3'h4;
			default: g.buf_on = 1'b0;
		endcase
		return g;
	endfunction : vrc_gain_decode

endpackage : vrc_pkg

// *** hdl/vrc_settle.sv ***
// settle timer: ready rises a fixed count after the reference is enabled
`include "vrc_regs.svh"

module vrc_settle
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic enable,
	output logic ready
);

	vrc_pkg::vrc_settle_s s_q;
	vrc_pkg::vrc_settle_s s_d;

	always_comb
	begin
		s_d = s_q;
		if (!enable)
		begin
			// restart on every disable so a quick re-enable waits the full time
			s_d.count = 8'h00;
			s_d.ready = 1'b0;
		end
		else if (!s_q.ready)
		begin
			s_d.count = s_q.count + 8'h01;
			if (s_d.count >= 8'(`VRC_SETTLE_CYCLES))
				s_d.ready = 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign ready = s_q.ready;

endmodule : vrc_settle

// *** test/vrc_top_monitor.sv ***
// concurrent checks on the reference control block ports
module vrc_mon
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic reference_enable,
	input wire logic reference_ready,
	input wire logic temp_sense_enable,
	input wire logic temp_range_select,
	input wire logic adc_ref_buf_on,
	input wire logic [2:0] adc_ref_gain_sel,
	input wire logic cmp_dac_buf_on,
	input wire logic [2:0] comparator_dac_gain_sel
);
	default clocking dc @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	chk_ready_off:
		assert property (!reference_enable |-> !reference_ready)
		else $error("ready while off");
	chk_ready_rise:
		assert property ($rose(reference_enable) |-> ##[1:4] reference_ready)
		else $error("ready late");
	chk_adc_dec:
		assert property ($onehot0(adc_ref_gain_sel) && adc_ref_buf_on == |adc_ref_gain_sel)
		else $error("adc decode");
	chk_cmp_dec:
		assert property ($onehot0(comparator_dac_gain_sel)
			&& cmp_dac_buf_on == |comparator_dac_gain_sel)
		else $error("cmp decode");
	chk_range_gate:
		assert property (temp_range_select |-> temp_sense_enable)
		else $error("range while off");
	chk_b_resp:
		assert property (s_axi_awvalid && s_axi_awready |-> ##[2:3] (s_axi_bvalid
			&& s_axi_bresp == ($past(s_axi_awaddr, 2) == 12'h90c ? 2'h0 : 2'h2)))
		else $error("write response");
	chk_b_hold:
		assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("response dropped");
	chk_ar_block:
		assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read overlap");
	cover property ($rose(reference_ready));
	cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	cover property (cmp_dac_buf_on && comparator_dac_gain_sel == 3'h4);
endmodule : vrc_mon

bind vrc_top vrc_mon vrc_mon_i (.*);

// *** test/vrc_top_test.sv ***
// self-checking bench for the reference control block
module vrc_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic s_axi_rready, reference_enable, reference_ready, temp_sense_enable;
	logic temp_range_select, adc_ref_buf_on, cmp_dac_buf_on;
	logic [11:0] s_axi_awaddr, s_axi_araddr, pin_q;
	logic [2:0] s_axi_awprot, s_axi_arprot, adc_ref_gain_sel, comparator_dac_gain_sel;
	logic [31:0] s_axi_wdata, s_axi_rdata, q;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [7:0] c;
	int fails, cmp_count;
	vrc_top dut (.*);
	assign pin_q = {reference_enable, reference_ready, temp_sense_enable, temp_range_select,
		adc_ref_buf_on, adc_ref_gain_sel, cmp_dac_buf_on, comparator_dac_gain_sel};
	function automatic logic [3:0] dec(input logic [1:0] g);
		return g == 2'h0 ? 4'h0 : {1'b1, 3'h1 << (g - 2'h1)};
	endfunction : dec
	function automatic logic [11:0] pins(input logic [7:0] v);
		return {v[7], v[7], v[5], v[5] & v[4], dec(v[1:0]), dec(v[3:2])};
	endfunction : pins
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			fails++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic end_sim;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	task automatic lim(input int n);
		if (n >= 50)
		begin
			chk(32'h0000_0000, 32'h0000_0001);
			end_sim;
		end
	endtask : lim
	task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [3:0] s);
		int n = 0;
		logic aw_done = 1'b0;
		logic w_done = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'($urandom), v};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		// each channel is released at its own handshake edge
		do
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (!(aw_done && w_done) && ++n < 50);
		// late bready makes the slave hold its response
		repeat ($urandom % 3) @(posedge aclk);
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (!s_axi_bvalid && ++n < 50);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
		lim(n);
	endtask : wr
	task automatic rd(input logic [11:0] a);
		int n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready && ++n < 50);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid && ++n < 50);
		q = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
		lim(n);
	endtask : rd
	task automatic fld(input logic [7:0] v);
		c = v;
		wr(12'h90c, v, 4'hf);
		chk(32'(r), 32'h0000_0000);
		repeat (6) @(posedge aclk);
		chk(32'(pin_q), 32'(pins(v)));
		rd(12'h90c);
		chk(q, {24'h00_0000, v[7], v[7], v[5:0]});
		chk(32'(r), 32'h0000_0000);
	endtask : fld
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb} = '0;
		fails = 0;
		cmp_count = 0;
		void'($urandom(32'hde27));
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(12'h90c);
		chk(q | 32'(pin_q), 32'h0000_0000);
		$display("reset test done");
		fld(8'h40);
		fld(8'hbf);
		for (int i = 0; i < 16; i++)
			fld(8'($urandom) & 8'hf0 | 8'(i));
		$display("field test done");
		wr(12'h908, ~c, 4'hf);
		chk(32'(r), 32'h0000_0002);
		wr(12'h90c, ~c, 4'h0);
		chk(32'(r), 32'h0000_0000);
		rd(12'h000);
		chk(q | 32'(r), 32'h0000_0002);
		rd(12'h90c);
		chk(q, {24'h00_0000, c[7], c[7], c[5:0]});
		$display("refusal test done");
		fld(8'hff);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(32'(pin_q), 32'h0000_0000);
		rd(12'h90c);
		chk(q | 32'(r), 32'h0000_0000);
		$display("mid-run reset test done");
		end_sim;
	end
endmodule : vrc_top_test
